/* File: logic/pad_cfg_map.svh */
// Purpose: offsets, field positions and reset values of the pad bank
// Assumes: 32-bit registers, one aligned word each
// Notes: definitions only
`ifndef PAD_CFG_MAP_SVH
`define PAD_CFG_MAP_SVH

`define PAD_FIRST_INDEX 18
`define PAD_COUNT 6
`define PAD18_OFFSET 12'h048
`define PAD19_OFFSET 12'h04c
`define PAD20_OFFSET 12'h050
`define PAD21_OFFSET 12'h054
`define PAD22_OFFSET 12'h058
`define PAD23_OFFSET 12'h05c

`define FLD_FUNC_LSB 0
`define FLD_FUNC_MSB 1
`define FLD_SRC_LSB 3
`define FLD_SRC_MSB 4
`define FLD_DRV_OFF_BIT 5
`define FLD_IDLE_LSB 6
`define FLD_IDLE_MSB 7
`define FLD_DRIVE_LSB 8
`define FLD_DRIVE_MSB 9
`define FLD_SLEW_BIT 10
`define FLD_RX_BIT 11
`define FLD_HYST_BIT 12

`define WRITABLE_MASK 32'h00001ffb

// reset images: pads 19, 20 pull down and receive on
`define RESET_PLAIN 32'h00000120
`define RESET_PULLED 32'h000009a0

`define SRC_LOCAL 2'h0
`define SRC_OTHER 2'h1
`define SRC_FABRIC 2'h2
`define IDLE_Z 2'h0
`define IDLE_UP 2'h1
`define IDLE_DOWN 2'h2
`define IDLE_KEEP 2'h3

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: logic/pad_cfg_pkg.sv */
// Purpose: types shared by the pad configuration bank
// Assumes: nothing
// Notes: no constants here; see pad_cfg_map.svh
package pad_cfg_pkg;

    typedef struct packed {
        logic hysteresis_on;
        logic rx_enable;
        logic edge_speed;
        logic [1:0] drive_code;
        logic [1:0] idle_state;
        logic driver_disable_n;
        logic [1:0] out_source;
        logic [1:0] alt_function_pick;
    } pad_ctrl_type;

    typedef enum logic [2:0] {
        wr_idle = 3'h1,
        wr_collect = 3'h2,
        wr_respond = 3'h4
    } wr_state_type;

endpackage

/* File: logic/pad_field_split.sv */
// Purpose: splits one stored register word into pad control fields
// Assumes: word already masked to writable bits
// Notes: pure decode, no state
`timescale 1ns/10ps
`include "pad_cfg_map.svh"

module pad_field_split (
    // stored word
    input wire logic [31:0] word,
    // pad controls
    output pad_cfg_pkg::pad_ctrl_type ctrl
);
    always_comb begin
        ctrl.alt_function_pick = word[`FLD_FUNC_MSB:`FLD_FUNC_LSB];
        ctrl.out_source = word[`FLD_SRC_MSB:`FLD_SRC_LSB];
        ctrl.driver_disable_n = word[`FLD_DRV_OFF_BIT];
        ctrl.idle_state = word[`FLD_IDLE_MSB:`FLD_IDLE_LSB];
        ctrl.drive_code = word[`FLD_DRIVE_MSB:`FLD_DRIVE_LSB];
        ctrl.edge_speed = word[`FLD_SLEW_BIT];
        ctrl.rx_enable = word[`FLD_RX_BIT];
        ctrl.hysteresis_on = word[`FLD_HYST_BIT];
    end
endmodule

/* File: logic/pad_config_bank.sv */
// Overview of operation
// - bits 1:0 pick the pad's alternate output function, reset zero
// - bits 4:3 pick output control: local regs, other logic, fabric; reset 0
// - bit 5 high disables the pad driver; resets high, drivers off
// - bits 7:6 idle state z/up/down/keep; pads 19,20 reset pull-down
// - bits 9:8 drive strength 2/4/8/12 mA, reset code one
// - bit 10 high fast edges, low slow edges; reset zero
// - bit 11 enables receiver; reset one for pads 19 and 20 only
// - bit 12 turns on input hysteresis; reset zero
//
// Purpose: AXI4-Lite register bank for pads 18 to 23
// Assumes: one write and one read in flight at most
// Notes: unmapped addresses answer SLVERR, reads return zero
`timescale 1ns/10ps
`include "pad_cfg_map.svh"

module pad_config_bank #(
    parameter int PADS = `PAD_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write address channel
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pad controls, one entry per pad
    output pad_cfg_pkg::pad_ctrl_type [PADS-1:0] pad_ctrl
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pad_cfg_pkg::wr_state_type wr_state;
        logic have_addr;
        logic have_data;
        logic [11:0] wr_addr;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [PADS-1:0][31:0] regs;
        pad_cfg_pkg::pad_ctrl_type [PADS-1:0] pads;
    } bank_state_type;

    bank_state_type cur;
    bank_state_type next_cur;
    pad_cfg_pkg::pad_ctrl_type [PADS-1:0] split_ctrl;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] decode_slot(input logic [11:0] addr);
        logic [3:0] slot;
        slot = 4'hf;
        case (addr)
            `PAD18_OFFSET: slot = 4'h0;
            `PAD19_OFFSET: slot = 4'h1;
            `PAD20_OFFSET: slot = 4'h2;
            `PAD21_OFFSET: slot = 4'h3;
            `PAD22_OFFSET: slot = 4'h4;
            `PAD23_OFFSET: slot = 4'h5;
            default: slot = 4'hf;
        endcase
        if (slot != 4'hf && 32'(slot) >= PADS) begin
            slot = 4'hf;
        end
        return slot;
    endfunction

    function automatic logic [31:0] reset_word(input int idx);
        logic [31:0] w;
        w = `RESET_PLAIN;
        if (idx + `PAD_FIRST_INDEX == 19 || idx + `PAD_FIRST_INDEX == 20) begin
            w = `RESET_PULLED;
        end
        return w;
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] w;
        w = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                w[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return w & `WRITABLE_MASK;
    endfunction

    // pad fields of a word, hole at bit 2 squeezed out
    function automatic pad_cfg_pkg::pad_ctrl_type word_ctrl(
            input logic [31:0] w);
        return {w[`FLD_HYST_BIT:`FLD_SRC_LSB],
            w[`FLD_FUNC_MSB:`FLD_FUNC_LSB]};
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] wslot;
        logic [3:0] rslot;
        next_cur = cur;
        next_cur.pads = split_ctrl;
        wslot = decode_slot(cur.wr_addr);
        rslot = decode_slot(araddr);
        // write address and data, either order
        if (awvalid && cur.awready) begin
            next_cur.have_addr = 1'b1;
            next_cur.wr_addr = awaddr;
            next_cur.awready = 1'b0;
        end
        if (wvalid && cur.wready) begin
            next_cur.have_data = 1'b1;
            next_cur.wr_data = wdata;
            next_cur.wr_strb = wstrb;
            next_cur.wready = 1'b0;
        end
        case (cur.wr_state)
            pad_cfg_pkg::wr_idle: begin
                next_cur.wr_state = pad_cfg_pkg::wr_collect;
            end
            pad_cfg_pkg::wr_collect: begin
                if (cur.have_addr && cur.have_data) begin
                    if (wslot != 4'hf) begin
                        next_cur.regs[wslot] = merge_strb(cur.regs[wslot],
                            cur.wr_data, cur.wr_strb);
                        next_cur.bresp = `AXI_RESP_OKAY;
                    end else begin
                        next_cur.bresp = `AXI_RESP_SLVERR;
                    end
                    next_cur.bvalid = 1'b1;
                    next_cur.have_addr = 1'b0;
                    next_cur.have_data = 1'b0;
                    next_cur.wr_state = pad_cfg_pkg::wr_respond;
                end
            end
            pad_cfg_pkg::wr_respond: begin
                if (bready) begin
                    next_cur.bvalid = 1'b0;
                    next_cur.awready = 1'b1;
                    next_cur.wready = 1'b1;
                    next_cur.wr_state = pad_cfg_pkg::wr_collect;
                end
            end
            default: begin
                next_cur.wr_state = pad_cfg_pkg::wr_idle;
            end
        endcase
        // read path: one outstanding read
        if (arvalid && cur.arready) begin
            next_cur.arready = 1'b0;
            next_cur.rvalid = 1'b1;
            if (rslot != 4'hf) begin
                next_cur.rdata = cur.regs[rslot];
                next_cur.rresp = `AXI_RESP_OKAY;
            end else begin
                next_cur.rdata = 32'h00000000;
                next_cur.rresp = `AXI_RESP_SLVERR;
            end
        end else if (cur.rvalid && rready) begin
            next_cur.rvalid = 1'b0;
            next_cur.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur.wr_state <= pad_cfg_pkg::wr_idle;
            cur.have_addr <= 1'b0;
            cur.have_data <= 1'b0;
            cur.wr_addr <= 12'h000;
            cur.wr_data <= 32'h00000000;
            cur.wr_strb <= 4'h0;
            cur.awready <= 1'b1;
            cur.wready <= 1'b1;
            cur.bvalid <= 1'b0;
            cur.bresp <= 2'h0;
            cur.arready <= 1'b1;
            cur.rvalid <= 1'b0;
            cur.rdata <= 32'h00000000;
            cur.rresp <= 2'h0;
            for (int i = 0; i < PADS; i++) begin
                cur.regs[i] <= reset_word(i);
                cur.pads[i] <= word_ctrl(reset_word(i));
            end
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // pad control outputs
    // ------------------------------------------------------------
    for (genvar g = 0; g < PADS; g++) begin : gen_split
        pad_field_split u_split (
            .word(cur.regs[g]),
            .ctrl(split_ctrl[g])
        );
    end

    // pad pins come straight from the registered copy
    assign pad_ctrl = cur.pads;

    assign awready = cur.awready;
    assign wready = cur.wready;
    assign bvalid = cur.bvalid;
    assign bresp = cur.bresp;
    assign arready = cur.arready;
    assign rvalid = cur.rvalid;
    assign rdata = cur.rdata;
    assign rresp = cur.rresp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_reserved_zero: assert property (@(posedge clk)
        disable iff (!nrst)
        rvalid |-> (rdata & ~`WRITABLE_MASK) == 32'h0)
        else $error("reserved bits read nonzero");

    chk_pad_follows: assert property (@(posedge clk)
        disable iff (!nrst)
        pad_ctrl[0] == word_ctrl($past(cur.regs[0])))
        else $error("pad controls lag register");

    chk_reset_image: assert property (@(posedge clk)
        !nrst |=> cur.regs[0] == `RESET_PLAIN &&
            cur.regs[1] == `RESET_PULLED &&
            pad_ctrl[0] == word_ctrl(`RESET_PLAIN) &&
            pad_ctrl[1] == word_ctrl(`RESET_PULLED))
        else $error("reset image wrong");

    chk_write_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD18_OFFSET &&
         cur.wr_strb == 4'hf)
        |=> ##1 pad_ctrl[0].driver_disable_n ==
            $past(cur.wr_data[`FLD_DRV_OFF_BIT], 2))
        else $error("driver enable not written");

    chk_src_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD19_OFFSET &&
         cur.wr_strb[0])
        |=> cur.regs[1][`FLD_SRC_MSB:`FLD_SRC_LSB] ==
            $past(cur.wr_data[`FLD_SRC_MSB:`FLD_SRC_LSB]))
        else $error("output source not written");

    chk_func_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD20_OFFSET &&
         cur.wr_strb[0])
        |=> ##1 pad_ctrl[2].alt_function_pick ==
            $past(cur.wr_data[`FLD_FUNC_MSB:`FLD_FUNC_LSB], 2))
        else $error("function select not written");

    chk_upper_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD21_OFFSET &&
         cur.wr_strb[1])
        |=> ##1 {pad_ctrl[3].hysteresis_on, pad_ctrl[3].rx_enable,
            pad_ctrl[3].edge_speed, pad_ctrl[3].drive_code} ==
            $past(cur.wr_data[12:8], 2))
        else $error("upper fields not written");

    chk_idle_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD22_OFFSET &&
         cur.wr_strb[0])
        |=> ##1 pad_ctrl[4].idle_state ==
            $past(cur.wr_data[`FLD_IDLE_MSB:`FLD_IDLE_LSB], 2))
        else $error("idle state not written");

    chk_slew_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD23_OFFSET &&
         cur.wr_strb[1])
        |=> ##1 pad_ctrl[5].edge_speed ==
            $past(cur.wr_data[`FLD_SLEW_BIT], 2))
        else $error("slew control not written");

    chk_rx_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD19_OFFSET &&
         cur.wr_strb[1])
        |=> ##1 pad_ctrl[1].rx_enable ==
            $past(cur.wr_data[`FLD_RX_BIT], 2))
        else $error("receive enable not written");

    chk_hyst_lands: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && cur.wr_addr == `PAD20_OFFSET &&
         cur.wr_strb[1])
        |=> ##1 pad_ctrl[2].hysteresis_on ==
            $past(cur.wr_data[`FLD_HYST_BIT], 2))
        else $error("hysteresis not written");

    chk_bad_write: assert property (@(posedge clk)
        disable iff (!nrst)
        (cur.wr_state == pad_cfg_pkg::wr_collect && cur.have_addr &&
         cur.have_data && decode_slot(cur.wr_addr) == 4'hf)
        |=> bresp == `AXI_RESP_SLVERR && cur.regs == $past(cur.regs))
        else $error("unmapped write not refused");

    chk_bresp_held: assert property (@(posedge clk)
        disable iff (!nrst)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    chk_read_answer: assert property (@(posedge clk)
        disable iff (!nrst)
        arvalid && arready |=> rvalid)
        else $error("read not answered next cycle");

endmodule

/* File: tb/pad_cell_model.sv */
// Purpose: behavioural pad cells fed by the bank's pad controls
// Assumes: one cell per pad, entry 0 is pad 18
// Notes: reports drive current, driver and resistor state
`timescale 1ns/10ps

module pad_cell_model #(
    parameter int PADS = 6
) (
    // pad controls from the bank
    input wire pad_cfg_pkg::pad_ctrl_type [PADS-1:0] pad_ctrl,
    // observed cell state
    output logic [PADS-1:0][3:0] drive_ma,
    output logic [PADS-1:0] driver_on,
    output logic [PADS-1:0] pulled_up,
    output logic [PADS-1:0] pulled_down
);
    always_comb begin
        for (int i = 0; i < PADS; i++) begin
            case (pad_ctrl[i].drive_code)
                2'h0: drive_ma[i] = 4'h2;
                2'h1: drive_ma[i] = 4'h4;
                2'h2: drive_ma[i] = 4'h8;
                default: drive_ma[i] = 4'hc;
            endcase
            driver_on[i] = !pad_ctrl[i].driver_disable_n;
            pulled_up[i] = pad_ctrl[i].idle_state == 2'h1;
            pulled_down[i] = pad_ctrl[i].idle_state == 2'h2;
        end
    end
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the pad configuration bank
// Assumes: AXI4-Lite master, answers awaited under a bound
// Notes: pad cells modelled in pad_cell_model
`timescale 1ns/10ps
`define chk(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end

module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    pad_cfg_pkg::pad_ctrl_type [5:0] pad_ctrl;
    logic [5:0][3:0] drive_ma;
    logic [5:0] driver_on, pulled_up, pulled_down;
    logic [31:0] mem [6];
    logic [3:0] ma [4] = '{4'h2, 4'h4, 4'h8, 4'hc};
    int fail_count = 0;
    int tests_run = 0;
    int bready_gap = 0;

    always #2.5 clk = ~clk;

    pad_config_bank #(.PADS(6)) i_dut (
        .clk(clk), .nrst(nrst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pad_ctrl(pad_ctrl)
    );

    pad_cell_model #(.PADS(6)) i_pads (
        .pad_ctrl(pad_ctrl), .drive_ma(drive_ma), .driver_on(driver_on),
        .pulled_up(pulled_up), .pulled_down(pulled_down)
    );

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    function automatic pad_cfg_pkg::pad_ctrl_type to_ctrl(
            input logic [31:0] w);
        return {w[12:3], w[1:0]};
    endfunction

    // reset images: pads 19 and 20 pull down, receiver on
    function automatic logic [31:0] rst_word(input int i);
        return (i == 1 || i == 2) ? 32'h000009a0 : 32'h00000120;
    endfunction

    task automatic chk_reset_pads();
        for (int k = 0; k < 6; k++) begin
            `chk("reset pad", to_ctrl(rst_word(k)), pad_ctrl[k])
            `chk("reset driver", 1'b0, driver_on[k])
        end
    endtask

    function automatic logic [11:0] addr_of(input int i);
        return 12'h048 + 12'(4 * i);
    endfunction

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (bready_gap == 0);
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
            if (n >= bready_gap) bready <= 1'b1;
        end while (!(bvalid && bready));
        `chk("b latency", (bready_gap > 2) ? bready_gap + 1 : 3, n)
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid);
        `chk("r latency", 2, n)
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic check_pad(input int k);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(addr_of(k), d, r);
        `chk("word", mem[k], d)
        `chk("rresp", 2'h0, r)
        `chk("pad ctrl", to_ctrl(mem[k]), pad_ctrl[k])
        `chk("drive mA", ma[mem[k][9:8]], drive_ma[k])
        `chk("driver on", ~mem[k][5], driver_on[k])
        `chk("pull up", mem[k][7:6] == 2'h1, pulled_up[k])
        `chk("pull down", mem[k][7:6] == 2'h2, pulled_down[k])
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            mem[i] = rst_word(i);
            check_pad(i);
        end
        $display("test reset done");
    endtask

    task automatic t_fields();
        logic [31:0] w;
        logic [1:0] r;
        for (int k = 0; k < 6; k++) begin
            w = {19'h7ffff, k[0], ~k[0], k[1], 2'(k + 1), 2'(k), k[0],
                2'(k % 3), 1'b1, 2'(k)};
            mem[k] = w & 32'h00001ffb;
            axi_write(addr_of(k), w, 4'hf, r);
            `chk("bresp", 2'h0, r)
        end
        for (int k = 0; k < 6; k++) begin
            check_pad(k);
        end
        $display("test fields done");
    endtask

    task automatic t_strobe();
        logic [1:0] r;
        bready_gap = 3;
        axi_write(addr_of(0), 32'h0, 4'h1, r);
        bready_gap = 0;
        `chk("strobe bresp", 2'h0, r)
        mem[0] = mem[0] & 32'h00001f00;
        check_pad(0);
        $display("test strobe done");
    endtask

    task automatic t_unmapped();
        logic [11:0] bad [3] = '{12'h060, 12'h04a, 12'h044};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 3; i++) begin
            axi_write(bad[i], 32'hffffffff, 4'hf, r);
            `chk("bad bresp", 2'h2, r)
            axi_read(bad[i], d, r);
            `chk("bad rresp", 2'h2, r)
            `chk("bad rdata", 32'h0, d)
        end
        for (int k = 0; k < 6; k++) begin
            check_pad(k);
        end
        $display("test unmapped done");
    endtask

    task automatic t_rereset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_reset_pads();
        nrst <= 1'b1;
        t_reset();
        $display("test rereset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        chk_reset_pads();
        nrst <= 1'b1;
        t_reset();
        t_fields();
        t_strobe();
        t_unmapped();
        t_rereset();
        finish_test();
    end

    initial begin
        #20000;
        fail_count++;
        $display("[ERR] watchdog exp done got hang");
        finish_test();
    end
endmodule
